// ==== rtl/hs_cmd_pkg.sv ====
/*
 * Constants, field layout and state type for the host command control block.
 * Assumes a single 20 MHz clock domain and one asynchronous active-low reset.
 */
package hs_cmd_pkg;

    // ==================================================================
    // Widths
    localparam int REG_W = 32;
    localparam int FIDX_W = 14;
    localparam int LIDX_W = 10;
    localparam int BASE_LSB = 12;

    // ==================================================================
    // Command register field positions
    localparam int CMD_RS_BIT = 0;
    localparam int CMD_RESET_BIT = 1;
    localparam int CMD_FLS_LSB = 2;
    localparam int CMD_FLS_MSB = 3;
    localparam int CMD_PSE_BIT = 4;

    // Status register and capability word positions
    localparam int STS_HALTED_BIT = 12;
    localparam int CAP_PROG_LIST_BIT = 1;

    // ==================================================================
    // Frame list size encodings
    localparam logic [1:0] FLS_1024 = 2'h0;
    localparam logic [1:0] FLS_512 = 2'h1;
    localparam logic [1:0] FLS_256 = 2'h2;
    localparam logic [1:0] FLS_RSVD = 2'h3;

    // ==================================================================
    // Reset values
    localparam logic [1:0] FLS_RESET = FLS_1024;
    localparam logic RS_RESET = 1'b0;
    localparam logic PSE_RESET = 1'b0;
    localparam logic SOFT_RESET_RESET = 1'b0;
    localparam logic HALTED_RESET = 1'b1;
    localparam logic [REG_W-1:0] RD_RESET = 32'h0000_0000;
    localparam logic [REG_W-1:0] STS_RESET = 32'h0000_1000;

    // ==================================================================
    // Timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int UFRAME_TIME_NS = 125000;
    localparam int UFRAME_CYCLES = UFRAME_TIME_NS / CLK_PERIOD_NS;
    localparam int UFRAMES_LOG2 = 3;
    localparam int SOFT_RESET_TIME_NS = 2000;
    localparam int SOFT_RESET_CYCLES = (SOFT_RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ==================================================================
    // Controller execution states
    typedef enum logic [1:0] {
        ST_HALTED,
        ST_RUNNING,
        ST_DRAINING,
        ST_RESETTING
    } ctrl_state_t;

endpackage

// ==== rtl/frame_index_counter.sv ====
/*
 * Microframe divider and frame index counter.
 * Assumes clear and run come from logic on the same clock.
 */
`timescale 1ns/1ns
module frame_index_counter #(
    parameter int UFRAME_CYCLES = hs_cmd_pkg::UFRAME_CYCLES,
    parameter int FIDX_W = hs_cmd_pkg::FIDX_W
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clear,
    input wire logic run,
    output logic [FIDX_W-1:0] frame_index_q,
    output logic uframe_tick_q
);
    import hs_cmd_pkg::*;

    localparam int DIV_W = $clog2(UFRAME_CYCLES + 1);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(UFRAME_CYCLES - 1);

    logic [DIV_W-1:0] div_q;

    // ==================================================================
    // Microframe divider
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div_q <= '0;
        end else if (clear || !run) begin
            div_q <= '0;
        end else if (div_q == DIV_LAST) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + DIV_W'(1);
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            uframe_tick_q <= 1'b0;
        end else begin
            uframe_tick_q <= run && !clear && (div_q == DIV_LAST);
        end
    end

    // ==================================================================
    // Frame index, one step per microframe
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            frame_index_q <= '0;
        end else if (clear) begin
            frame_index_q <= '0;
        end else if (run && (div_q == DIV_LAST)) begin
            frame_index_q <= frame_index_q + FIDX_W'(1);
        end
    end

endmodule

// ==== rtl/hs_host_command_control.sv ====
/*
 * Command control of a high-speed host controller: run/stop with halted
 * reporting, the software controller reset sequence, periodic schedule
 * enable, frame list size and periodic list fetch addressing.
 * Assumes every input comes from logic on the same clock; the pipeline
 * busy level and port requests are driven by neighbouring blocks.
 */
//
// Summary of operation
// [RL1] Periodic fetches start at the base held in the periodic list base.
// [RL2] Frame list size resets to 00b; writable only with capability bit 1.
// [RL3] Size 00b is 1024 entries, 01b 512, 10b 256, 11b reserved.
// [RL4] Selected size picks which frame index bits form the list index.
// [RL5] Soft reset returns pipelines, timers, counters and state machines to start.
// [RL6] Soft reset restores operational and per-port registers and port state.
// [RL7] Soft reset aborts the transaction in flight and drives no bus reset.
// [RL8] Soft reset leaves host-bus configuration registers untouched.
// [RL9] Soft reset hands every downstream port back to companion controllers.
// [RL10] Hardware clears the reset bit when done; writing zero cannot end it.
// [RL11] Software reinitialises the controller after a soft reset.
// [RL12] Software checks halted before asking for a soft reset.
// [RL13] Run/stop one means run; the schedule executes while it is set.
// [RL14] Clearing run/stop drains the pipeline, then the controller halts.
// [RL15] Halted flag reports that draining finished and the controller stopped.
// [RL16] Software sees halted at one before setting run/stop.
// [RL17] Periodic enable resets to zero; at zero the periodic schedule is skipped.
// [RL18] Halted resets to one, reads zero while running, sets on any stop.
// [RL19] Without capability, size writes are dropped and the default stays.
`timescale 1ns/1ns
module hs_host_command_control #(
    parameter int NUM_PORTS = 4,
    parameter int UFRAME_CYCLES = hs_cmd_pkg::UFRAME_CYCLES,
    parameter int SOFT_RESET_CYCLES = hs_cmd_pkg::SOFT_RESET_CYCLES
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic cmd_wr_en,
    input wire logic [hs_cmd_pkg::REG_W-1:0] cmd_wr_data,
    output logic [hs_cmd_pkg::REG_W-1:0] cmd_rd_data,
    output logic [hs_cmd_pkg::REG_W-1:0] status_rd_data,
    input wire logic [hs_cmd_pkg::REG_W-1:0] capability_parameters,
    input wire logic [hs_cmd_pkg::REG_W-1:0] periodic_list_base_a,
    input wire logic pipe_busy,
    input wire logic hw_stop_req,
    input wire logic port_claim_wr,
    input wire logic [NUM_PORTS-1:0] port_claim_data,
    input wire logic [NUM_PORTS-1:0] port_reset_req,
    output logic schedule_exec,
    output logic periodic_fetch_req,
    output logic [hs_cmd_pkg::REG_W-1:0] periodic_fetch_addr,
    output logic [hs_cmd_pkg::LIDX_W-1:0] list_index,
    output logic txn_abort,
    output logic soft_reset_active,
    output logic [NUM_PORTS-1:0] port_companion_owned,
    output logic [NUM_PORTS-1:0] port_bus_reset
);
    import hs_cmd_pkg::*;

    localparam int RCNT_W = $clog2(SOFT_RESET_CYCLES + 1);
    localparam logic [RCNT_W-1:0] RCNT_LAST = RCNT_W'(SOFT_RESET_CYCLES - 1);

    // ==================================================================
    // Frame list index selection
    // [RL3] [RL4] Size picks index bits.
    function automatic logic [LIDX_W-1:0] frame_list_index(
        input logic [1:0] fls,
        input logic [FIDX_W-1:0] fidx
    );
        logic [LIDX_W-1:0] idx;
        idx = fidx[12:3];
        case (fls)
            FLS_1024: begin
                idx = fidx[12:3];
            end
            FLS_512: begin
                idx = {1'b0, fidx[11:3]};
            end
            FLS_256: begin
                idx = {2'b00, fidx[10:3]};
            end
            default: begin
                // The reserved code is walked like the full list so fetches stay in range.
                idx = fidx[12:3];
            end
        endcase
        return idx;
    endfunction

    ctrl_state_t state_q;
    logic rs_q;
    logic soft_reset_q;
    logic pse_q;
    logic [1:0] fls_q;
    logic halted_q;
    logic [RCNT_W-1:0] rcnt_q;
    logic [REG_W-1:0] cmd_rd_q;
    logic [REG_W-1:0] status_rd_q;
    logic exec_q;
    logic fetch_req_q;
    logic [REG_W-1:0] fetch_addr_q;
    logic [LIDX_W-1:0] list_index_q;
    logic abort_q;
    logic [NUM_PORTS-1:0] owner_q;
    logic [NUM_PORTS-1:0] bus_reset_q;
    logic [FIDX_W-1:0] frame_index;
    logic uframe_tick;
    logic reset_start;
    logic resetting;
    logic sw_write;
    logic fidx_clear;
    logic fidx_run;

    assign resetting = soft_reset_q;
    // [RL12] Requests while not halted are taken anyway; software avoids them.
    assign reset_start = cmd_wr_en && cmd_wr_data[CMD_RESET_BIT] && !soft_reset_q;
    // Field writes that coincide with a reset request are dropped, the reset wins.
    assign sw_write = cmd_wr_en && !soft_reset_q && !cmd_wr_data[CMD_RESET_BIT];
    assign fidx_clear = reset_start || resetting;
    assign fidx_run = (state_q == ST_RUNNING);

    // ==================================================================
    // Soft reset sequence
    // [RL10] Self-clearing reset bit.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            soft_reset_q <= SOFT_RESET_RESET;
        end else if (reset_start) begin
            soft_reset_q <= 1'b1;
        end else if (soft_reset_q && (rcnt_q == RCNT_LAST)) begin
            soft_reset_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rcnt_q <= '0;
        end else if (!soft_reset_q) begin
            rcnt_q <= '0;
        end else begin
            rcnt_q <= rcnt_q + RCNT_W'(1);
        end
    end

    // ==================================================================
    // Run/stop control
    // [RL13] Run/stop bit storage.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rs_q <= RS_RESET;
        end else if (reset_start || resetting) begin
            rs_q <= RS_RESET;
        end else if (hw_stop_req) begin
            // [RL18] Hardware stop clears run.
            rs_q <= 1'b0;
        end else if (sw_write) begin
            rs_q <= cmd_wr_data[CMD_RS_BIT];
        end
    end

    // ==================================================================
    // Schedule enable and frame list size
    // [RL17] Periodic enable defaults off.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pse_q <= PSE_RESET;
        end else if (reset_start || resetting) begin
            pse_q <= PSE_RESET;
        end else if (sw_write) begin
            pse_q <= cmd_wr_data[CMD_PSE_BIT];
        end
    end

    // [RL2] [RL19] Size writable with capability.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fls_q <= FLS_RESET;
        end else if (reset_start || resetting) begin
            fls_q <= FLS_RESET;
        end else if (sw_write && capability_parameters[CAP_PROG_LIST_BIT]) begin
            fls_q <= cmd_wr_data[CMD_FLS_MSB:CMD_FLS_LSB];
        end
    end

    // ==================================================================
    // Execution state machine
    // [RL5] [RL14] Drain, halt and reset states.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= ST_HALTED;
        end else if (reset_start) begin
            state_q <= ST_RESETTING;
        end else begin
            case (state_q)
                ST_HALTED: begin
                    if (rs_q) begin
                        state_q <= ST_RUNNING;
                    end
                end
                ST_RUNNING: begin
                    if (!rs_q) begin
                        state_q <= ST_DRAINING;
                    end
                end
                ST_DRAINING: begin
                    // A restart during draining waits for the halt, so no
                    // transaction is cut off.
                    if (!pipe_busy) begin
                        state_q <= ST_HALTED;
                    end
                end
                ST_RESETTING: begin
                    if (soft_reset_q && (rcnt_q == RCNT_LAST)) begin
                        state_q <= ST_HALTED;
                    end
                end
                default: begin
                    state_q <= ST_HALTED;
                end
            endcase
        end
    end

    // [RL15] [RL18] Halted follows the state.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            halted_q <= HALTED_RESET;
        end else begin
            halted_q <= (state_q == ST_HALTED) || (state_q == ST_RESETTING);
        end
    end

    // [RL13] [RL14] Schedule executes while running or draining.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            exec_q <= 1'b0;
        end else begin
            exec_q <= !reset_start
                && ((state_q == ST_RUNNING) || (state_q == ST_DRAINING));
        end
    end

    // [RL7] Abort pulse on reset entry.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            abort_q <= 1'b0;
        end else begin
            abort_q <= reset_start;
        end
    end

    // ==================================================================
    // Frame index and periodic fetch
    // [RL5] Counters cleared by the reset sequence.
    frame_index_counter #(
        .UFRAME_CYCLES(UFRAME_CYCLES),
        .FIDX_W(FIDX_W)
    ) u_fidx (
        .clk(clk),
        .arst_n(arst_n),
        .clear(fidx_clear),
        .run(fidx_run),
        .frame_index_q(frame_index),
        .uframe_tick_q(uframe_tick)
    );

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            list_index_q <= '0;
        end else begin
            list_index_q <= frame_list_index(fls_q, frame_index);
        end
    end

    // [RL1] [RL17] Fetch from base when enabled.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fetch_req_q <= 1'b0;
            fetch_addr_q <= RD_RESET;
        end else begin
            fetch_req_q <= 1'b0;
            if (uframe_tick && pse_q && (state_q == ST_RUNNING) && !reset_start
                    && (frame_index[UFRAMES_LOG2-1:0] == '0)) begin
                fetch_req_q <= 1'b1;
                fetch_addr_q <= {periodic_list_base_a[REG_W-1:BASE_LSB],
                                 frame_list_index(fls_q, frame_index), 2'b00};
            end
        end
    end

    // ==================================================================
    // Port ownership and port reset signalling
    // [RL6] [RL9] Ports revert to companion.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            owner_q <= '1;
        end else if (reset_start || resetting) begin
            owner_q <= '1;
        end else if (port_claim_wr) begin
            owner_q <= port_claim_data;
        end
    end

    // [RL7] No bus reset during soft reset.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bus_reset_q <= '0;
        end else if (reset_start || resetting) begin
            bus_reset_q <= '0;
        end else begin
            bus_reset_q <= port_reset_req;
        end
    end

    // ==================================================================
    // Read-back
    // [RL8] Capability input is only read, never reset here.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cmd_rd_q <= RD_RESET;
            status_rd_q <= STS_RESET;
        end else begin
            cmd_rd_q <= RD_RESET;
            cmd_rd_q[CMD_RS_BIT] <= rs_q;
            cmd_rd_q[CMD_RESET_BIT] <= soft_reset_q;
            cmd_rd_q[CMD_FLS_MSB:CMD_FLS_LSB] <= fls_q;
            cmd_rd_q[CMD_PSE_BIT] <= pse_q;
            status_rd_q <= RD_RESET;
            status_rd_q[STS_HALTED_BIT] <= halted_q;
        end
    end

    assign cmd_rd_data = cmd_rd_q;
    assign status_rd_data = status_rd_q;
    assign schedule_exec = exec_q;
    assign periodic_fetch_req = fetch_req_q;
    assign periodic_fetch_addr = fetch_addr_q;
    assign list_index = list_index_q;
    assign txn_abort = abort_q;
    assign soft_reset_active = soft_reset_q;
    assign port_companion_owned = owner_q;
    assign port_bus_reset = bus_reset_q;

endmodule

// ==== tb/hs_cmd_ctrl_sva.sv ====
/*
 * Concurrent checks on the ports of the host command control block.
 * Assumes one clock domain and an active-low asynchronous reset.
 */
`timescale 1ns/1ns
module hs_cmd_ctrl_chk #(
    parameter int NUM_PORTS = 4,
    parameter int SOFT_RESET_CYCLES = 40
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [hs_cmd_pkg::REG_W-1:0] cmd_rd_data,
    input wire logic [hs_cmd_pkg::REG_W-1:0] status_rd_data,
    input wire logic [hs_cmd_pkg::REG_W-1:0] capability_parameters,
    input wire logic [hs_cmd_pkg::REG_W-1:0] periodic_list_base_a,
    input wire logic pipe_busy,
    input wire logic schedule_exec,
    input wire logic periodic_fetch_req,
    input wire logic [hs_cmd_pkg::REG_W-1:0] periodic_fetch_addr,
    input wire logic txn_abort,
    input wire logic soft_reset_active,
    input wire logic [NUM_PORTS-1:0] port_companion_owned,
    input wire logic [NUM_PORTS-1:0] port_bus_reset
);
    import hs_cmd_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    // A plain repetition cannot carry a parameter count, so the length is counted here.
    logic [7:0] rst_len_q;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) rst_len_q <= 8'h00;
        else if (soft_reset_active) rst_len_q <= rst_len_q + 8'h01;
        else rst_len_q <= 8'h00;
    end
    sequence s_rst_enter;
        $rose(soft_reset_active);
    endsequence
    sequence s_rst_leave;
        $fell(soft_reset_active);
    endsequence
    sequence s_in_rst;
        soft_reset_active [*2];
    endsequence
    property p_abort;
        s_rst_enter |-> txn_abort ##1 !txn_abort;
    endproperty
    a_abort: assert property (p_abort) else $error("abort pulse wrong at reset start");
    property p_owned;
        soft_reset_active |-> &port_companion_owned;
    endproperty
    a_owned: assert property (p_owned) else $error("ports not with companion");
    property p_no_bus_reset;
        soft_reset_active |-> port_bus_reset == '0;
    endproperty
    a_no_bus_reset: assert property (p_no_bus_reset) else $error("bus reset driven");
    property p_rst_len;
        s_rst_leave |-> rst_len_q == SOFT_RESET_CYCLES;
    endproperty
    a_rst_len: assert property (p_rst_len) else $error("soft reset length wrong");
    property p_rst_regs;
        s_in_rst |-> cmd_rd_data == 32'h0000_0002 && status_rd_data[STS_HALTED_BIT];
    endproperty
    a_rst_regs: assert property (p_rst_regs) else $error("registers not initial");
    property p_exec_halt;
        !status_rd_data[STS_HALTED_BIT] |-> $past(schedule_exec);
    endproperty
    a_exec_halt: assert property (p_exec_halt) else $error("running without exec");
    property p_drain;
        $fell(schedule_exec) && !soft_reset_active |-> !$past(pipe_busy, 2);
    endproperty
    a_drain: assert property (p_drain) else $error("halted with busy pipeline");
    property p_fetch_addr;
        periodic_fetch_req |-> periodic_fetch_addr[31:12] == periodic_list_base_a[31:12]
            && periodic_fetch_addr[1:0] == 2'b00;
    endproperty
    a_fetch_addr: assert property (p_fetch_addr) else $error("fetch base wrong");
    property p_fls_cap;
        !capability_parameters[CAP_PROG_LIST_BIT]
            |-> cmd_rd_data[CMD_FLS_MSB:CMD_FLS_LSB] == FLS_RESET;
    endproperty
    a_fls_cap: assert property (p_fls_cap) else $error("size changed without cap");
    property p_pse_skip;
        !cmd_rd_data[CMD_PSE_BIT] |-> !periodic_fetch_req;
    endproperty
    a_pse_skip: assert property (p_pse_skip) else $error("fetch while disabled");
endmodule

bind hs_host_command_control hs_cmd_ctrl_chk #(.NUM_PORTS(NUM_PORTS),
    .SOFT_RESET_CYCLES(SOFT_RESET_CYCLES)) u_chk (.clk(clk), .arst_n(arst_n),
    .cmd_rd_data(cmd_rd_data), .status_rd_data(status_rd_data),
    .capability_parameters(capability_parameters), .periodic_list_base_a(periodic_list_base_a),
    .pipe_busy(pipe_busy), .schedule_exec(schedule_exec), .periodic_fetch_req(periodic_fetch_req),
    .periodic_fetch_addr(periodic_fetch_addr), .txn_abort(txn_abort),
    .soft_reset_active(soft_reset_active), .port_companion_owned(port_companion_owned),
    .port_bus_reset(port_bus_reset));

// ==== tb/usb_pipe_model.sv ====
/*
 * Model of the USB transaction pipeline beside the command block.
 * Assumes start_txn is a one-cycle pulse from the bench.
 */
`timescale 1ns/1ns
module usb_pipe_model #(
    parameter int HOLD = 20
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic start_txn,
    input wire logic txn_abort,
    output logic pipe_busy
);
    logic [7:0] left_q;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) left_q <= 8'h00;
        else if (txn_abort) left_q <= 8'h00;
        else if (start_txn) left_q <= 8'(HOLD);
        else if (left_q != 8'h00) left_q <= left_q - 8'h01;
    end
    assign pipe_busy = (left_q != 8'h00);
endmodule

// ==== tb/tb_hs_host_command_control.sv ====
/*
 * Self-checking bench for the host command control block.
 * Assumes the design package and the pipeline model are compiled first.
 */
`timescale 1ns/1ns
module tb_hs_host_command_control;
    import hs_cmd_pkg::*;
    localparam int SR = 4;
    localparam logic [31:0] BASE = 32'h1234_5000;
    logic clk, arst_n, cmd_wr_en, pipe_busy, hw_stop_req, port_claim_wr, start_txn, halted;
    logic schedule_exec, periodic_fetch_req, txn_abort, soft_reset_active;
    logic [31:0] cmd_wr_data, cmd_rd_data, status_rd_data, capability_parameters;
    logic [31:0] periodic_fetch_addr;
    logic [3:0] port_claim_data, port_reset_req, port_companion_owned, port_bus_reset;
    logic [LIDX_W-1:0] list_index;
    int error_cnt = 0;
    int compares = 0;
    int abort_cnt = 0;
    int n, k, mask;
    logic [31:0] rows [6][2] = '{'{32'h0000_0004, 32'h0000_0004},
        '{32'h0000_0008, 32'h0000_0008}, '{32'h0000_000C, 32'h0000_000C},
        '{32'h0000_0010, 32'h0000_0010}, '{32'hFFFF_FFFC, 32'h0000_001C},
        '{32'h0000_0000, 32'h0000_0000}};
    hs_host_command_control #(.NUM_PORTS(4), .UFRAME_CYCLES(4), .SOFT_RESET_CYCLES(SR)) DUT (
        .clk(clk), .arst_n(arst_n), .cmd_wr_en(cmd_wr_en), .cmd_wr_data(cmd_wr_data),
        .cmd_rd_data(cmd_rd_data), .status_rd_data(status_rd_data),
        .capability_parameters(capability_parameters), .periodic_list_base_a(BASE),
        .pipe_busy(pipe_busy), .hw_stop_req(hw_stop_req), .port_claim_wr(port_claim_wr),
        .port_claim_data(port_claim_data), .port_reset_req(port_reset_req),
        .schedule_exec(schedule_exec), .periodic_fetch_req(periodic_fetch_req),
        .periodic_fetch_addr(periodic_fetch_addr), .list_index(list_index),
        .txn_abort(txn_abort), .soft_reset_active(soft_reset_active),
        .port_companion_owned(port_companion_owned), .port_bus_reset(port_bus_reset));
    usb_pipe_model u_pipe (.clk(clk), .arst_n(arst_n), .start_txn(start_txn),
        .txn_abort(txn_abort), .pipe_busy(pipe_busy));
    always_comb halted = status_rd_data[STS_HALTED_BIT];
    always @(posedge clk) if (txn_abort === 1'b1) abort_cnt++;

    // ==================================================================
    // Tasks
    task automatic cyc(input int c);
        repeat (c) @(posedge clk);
    endtask
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [31:0] d);
        cmd_wr_data <= d;
        cmd_wr_en <= 1'b1;
        @(posedge clk);
        cmd_wr_en <= 1'b0;
    endtask
    // Bounded wait; a miss counts as a mismatch rather than hanging the run.
    task automatic wait_for(ref logic s, input logic v, input int lim);
        for (int i = 0; i < lim && s !== v; i++) @(posedge clk);
        cmp("wait", 32'(v), 32'(s));
    endtask
    task automatic done(input string name);
        $display("test %s finished", name);
    endtask
    task automatic complete_run;
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ==================================================================
    // Clock and watchdog
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        #(80000 * 50);
        error_cnt++;
        $display("wrong value watchdog expected finish seen timeout");
        complete_run();
    end

    // ==================================================================
    // Main sequence
    initial begin
        {arst_n, cmd_wr_en, hw_stop_req, port_claim_wr, start_txn} = 5'b00000;
        {cmd_wr_data, capability_parameters} = '0;
        {port_claim_data, port_reset_req} = '0;
        cyc(5);
        arst_n <= 1'b1;
        cyc(2);
        cmp("cmd reset", 32'h0000_0000, cmd_rd_data);
        cmp("status reset", STS_RESET, status_rd_data);
        cmp("owned reset", 32'h0000_000F, 32'(port_companion_owned));
        done("reset");
        wr(32'h0000_000C);
        cyc(2);
        cmp("size no cap", 32'h0000_0000, cmd_rd_data);
        capability_parameters <= 32'h0000_0002;
        foreach (rows[i]) begin
            wr(rows[i][0]);
            cyc(2);
            cmp("cmd row", rows[i][1], cmd_rd_data);
        end
        done("fields");
        wr(32'h0000_0011);
        cyc(4);
        cmp("status run", 32'h0000_0000, status_rd_data);
        cmp("exec run", 32'h0000_0001, 32'(schedule_exec));
        start_txn <= 1'b1;
        wr(32'h0000_0010);
        start_txn <= 1'b0;
        cyc(8);
        cmp("exec drain", 32'h0000_0001, 32'(schedule_exec));
        wait_for(halted, 1'b1, 40);
        cyc(1);
        cmp("exec halted", 32'h0000_0000, 32'(schedule_exec));
        wr(32'h0000_0001);
        cyc(40);
        hw_stop_req <= 1'b1;
        cyc(1);
        hw_stop_req <= 1'b0;
        wait_for(halted, 1'b1, 20);
        cyc(1);
        cmp("hw stop", 32'h0000_0000, cmd_rd_data);
        done("run stop");
        port_claim_wr <= 1'b1;
        port_reset_req <= 4'hA;
        cyc(1);
        port_claim_wr <= 1'b0;
        cyc(2);
        cmp("owned claim", 32'h0000_0000, 32'(port_companion_owned));
        cmp("bus reset", 32'h0000_000A, 32'(port_bus_reset));
        n = abort_cnt;
        wr(32'h0000_0013);
        cyc(1);
        wr(32'h0000_0000);
        cmp("owned soft", 32'h0000_000F, 32'(port_companion_owned));
        cmp("bus reset soft", 32'h0000_0000, 32'(port_bus_reset));
        k = 0;
        while (soft_reset_active === 1'b1 && k < 100) begin
            @(posedge clk);
            k++;
        end
        cmp("reset length", 32'(SR - 1), 32'(k));
        cyc(2);
        cmp("abort", 32'(n + 1), 32'(abort_cnt));
        cmp("cmd soft", 32'h0000_0000, cmd_rd_data);
        cmp("status soft", STS_RESET, status_rd_data);
        done("soft reset");
        // Long enough to wrap the smaller lists, so each size shows its own index bits.
        for (int f = 0; f < 4; f++) begin
            wr(32'h0000_0002);
            cyc(2);
            wait_for(soft_reset_active, 1'b0, 20);
            wr((32'(f) << 2) | 32'h0000_0011);
            mask = (f == 1) ? 511 : (f == 2) ? 255 : 1023;
            for (int j = 1; j <= 512; j++) begin
                wait_for(periodic_fetch_req, 1'b1, 64);
                cmp("fetch addr", {BASE[31:12], 10'(j & mask), 2'b00}, periodic_fetch_addr);
                cmp("list index", 32'(j & mask), 32'(list_index));
                cyc(1);
            end
            wr(32'h0000_0010);
            wait_for(halted, 1'b1, 40);
        end
        done("frame list");
        complete_run();
    end
endmodule
